// ### src/umf_pkg.sv
// Package for the upstream fragmentation engine: register map, field layouts,
// overhead figures and timing counts shared by the engine and its helpers.
// Assumes a 100 MHz single clock and a 32-bit AHB-Lite register bus.
package umf_pkg;

  localparam int unsigned CLK_MHZ           = 100;
  localparam logic [7:0]  ADDR_CTRL         = 8'h00;
  localparam logic [7:0]  ADDR_STATUS       = 8'h04;
  localparam logic [7:0]  ADDR_REQ          = 8'h08;
  localparam logic [7:0]  ADDR_GRANT        = 8'h0C;
  localparam logic [7:0]  ADDR_FRAG         = 8'h10;
  localparam logic [7:0]  ADDR_POH          = 8'h14;
  localparam logic [7:0]  ADDR_ACKTIME      = 8'h18;
  localparam logic [7:0]  ADDR_NEXTPKT      = 8'h1C;
  localparam logic [7:0]  ADDR_COUNT        = 8'h20;

  // Control field positions
  localparam int unsigned CTRL_EN_BIT       = 0;
  localparam int unsigned CTRL_CONCAT_BIT   = 1;
  localparam int unsigned CTRL_IMM_BIT      = 2;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;

  // Grant register fields
  localparam int unsigned GR_LEN_LSB        = 0;
  localparam int unsigned GR_PEND_BIT       = 16;
  localparam int unsigned GR_MORE_BIT       = 17;

  // Frame-size and mini-slot arithmetic
  localparam logic [15:0] FRAG_OVH_BYTES    = 16'h0010;
  localparam logic [15:0] BYTES_PER_SLOT    = 16'h0010;
  localparam logic [7:0]  RETRY_LIMIT_RESET = 8'h10;
  localparam logic [31:0] ACK_TIME_RESET    = 32'h0000_2710;
  localparam logic [15:0] POH_RESET         = 16'h0020;

  typedef enum logic [2:0] {
    UMF_IDLE,
    UMF_WAIT_GRANT,
    UMF_SEND,
    UMF_WAIT_FRAG,
    UMF_DROP
  } umf_state_t;

  // Mini-slots needed for a payload with overhead, rounded up
  function automatic logic [7:0] umf_slots(input logic [15:0] bytes,
                                           input logic [15:0] phy_layer_overhead);
    logic [16:0] total;
    logic [16:0] s;
    total = {1'b0, bytes} + {1'b0, phy_layer_overhead} + 17'(BYTES_PER_SLOT) - 17'h0_0001;
    s     = total / 17'(BYTES_PER_SLOT);
    return (s > 17'h0_00FF) ? 8'hFF : s[7:0];
  endfunction

endpackage

// ### src/umf_ack_timer.sv
// Acknowledgement timer: counts down a programmable number of cycles.
// Assumes start and stop are single-cycle pulses on the same clock.
module umf_ack_timer import umf_pkg::*; (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [31:0] load,
  output logic             expired
);

  logic [31:0] count_q;
  logic        run_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_q <= 32'h0000_0000;
      run_q   <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        count_q <= (load == 32'h0000_0000) ? 32'h0000_0001 : load;
        run_q   <= 1'b1;
      end else if (stop) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        if (count_q == 32'h0000_0001) begin
          run_q   <= 1'b0;
          expired <= 1'b1;
        end
        count_q <= count_q - 32'h0000_0001;
      end
    end
  end

endmodule

// ### src/umf_hdr_build.sv
// Fragment header assembler: packs the flags, sequence number and piggyback
// request into one word for the transmit path. Purely registered.
module umf_hdr_build import umf_pkg::*; (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        load,
  input  wire logic        first,
  input  wire logic        last,
  input  wire logic [3:0]  seq,
  input  wire logic [7:0]  piggy,
  input  wire logic [15:0] payload_len,
  output logic [31:0]      header
);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      header <= 32'h0000_0000;
    end else if (load) begin
      header <= {first, last, 2'b00, seq, piggy, payload_len};
    end
  end

endmodule

// ### src/umf_engine.sv
// Upstream MAC-frame fragmentation engine of the modem, with AHB-Lite registers.
// Assumes software posts frame length and grants through registers and
// reads each built fragment header; one clock, asynchronous active-high reset.
//
// Notes on behaviour
// - Piggyback mode: remainder reported in header
// - One modem rule set for both modes
// - No grant nor pending: re-request remainder
// - Grant with pending: no piggyback request
// - No further grant: piggyback, track remainder
// - Piggyback covers remainder plus all overheads
// - Short grant: usable bytes minus sixteen
// - Grants queued: zero piggyback, await grant
// - None queued: piggyback slots, start timer
// - Timer expiry: request remainder with overheads
// - Fits: last fragment, else middle
// - Last fragment request zero or next
// - Retry on expiry until limit, then drop
// - Concatenated frame fragmented as one unit
// - After last, normal; restart on shortfall
// - First/middle/last flag settings
// - Sequence number increments per fragment
// - Never fragment immediate-data frames
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
module umf_engine import umf_pkg::*; (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             frag_valid,
  output logic [31:0]      fragment_header,
  output logic             req_valid,
  output logic [7:0]       req_slots
);

  logic [31:0] ctrl_q;
  logic [15:0] frame_len_q;
  logic [15:0] remain_q;
  logic [15:0] poh_q;
  logic [31:0] ack_time_q;
  logic [7:0]  retry_limit_q;
  logic [7:0]  retries_q;
  logic [15:0] next_pkt_q;
  logic [15:0] frags_sent_q;
  logic [15:0] drops_q;
  logic [3:0]  seq_q;
  logic        frag_active_q;
  logic        last_q;
  logic        dropped_q;
  logic        req_post_q;
  logic        grant_post_q;
  logic [31:0] grant_q;
  umf_state_t  state_q;

  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        acc_ok;
  logic        wr_now;

  logic        tmr_start;
  logic        tmr_stop;
  logic        tmr_expired;
  logic        hdr_load;
  logic        hdr_first;
  logic        hdr_last;
  logic [7:0]  hdr_piggy;
  logic [15:0] hdr_len;

  logic [15:0] g_len;
  logic        g_pend;
  logic        g_more;
  logic [15:0] g_usable;
  logic [15:0] g_payload;
  logic        g_fits;
  logic        g_short;
  logic [15:0] after_rem;

  // Bus slave: zero-wait, always OKAY
  assign acc_ok = hsel && hready && htrans[1];
  assign wr_now = wr_pend_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc_ok && hwrite;
      if (acc_ok) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (acc_ok && !hwrite) begin
      case (haddr[7:0])
        ADDR_CTRL:    hrdata <= ctrl_q;
        ADDR_STATUS:  hrdata <= {16'h0000, remain_q[7:0], seq_q, last_q,
                                 dropped_q, frag_active_q, state_q != UMF_IDLE};
        ADDR_REQ:     hrdata <= {16'h0000, frame_len_q};
        ADDR_GRANT:   hrdata <= grant_q;
        ADDR_FRAG:    hrdata <= fragment_header;
        ADDR_POH:     hrdata <= {16'h0000, poh_q};
        ADDR_ACKTIME: hrdata <= ack_time_q;
        ADDR_NEXTPKT: hrdata <= {8'h00, retry_limit_q, next_pkt_q};
        ADDR_COUNT:   hrdata <= {drops_q, frags_sent_q};
        default:      hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_q        <= CTRL_RESET;
      poh_q         <= POH_RESET;
      ack_time_q    <= ACK_TIME_RESET;
      retry_limit_q <= RETRY_LIMIT_RESET;
      next_pkt_q    <= 16'h0000;
    end else if (wr_now) begin
      case (wr_addr_q)
        ADDR_CTRL:    ctrl_q <= hwdata;
        ADDR_POH:     poh_q <= hwdata[15:0];
        ADDR_ACKTIME: ack_time_q <= hwdata;
        ADDR_NEXTPKT: begin
          next_pkt_q    <= hwdata[15:0];
          retry_limit_q <= hwdata[23:16];
        end
        default: ;
      endcase
    end
  end

  // Posting strobes: a write to REQ or GRANT hands work to the engine
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frame_len_q  <= 16'h0000;
      grant_q      <= 32'h0000_0000;
      req_post_q   <= 1'b0;
      grant_post_q <= 1'b0;
    end else begin
      req_post_q   <= wr_now && (wr_addr_q == ADDR_REQ);
      grant_post_q <= wr_now && (wr_addr_q == ADDR_GRANT);
      if (wr_now && wr_addr_q == ADDR_REQ) begin
        frame_len_q <= hwdata[15:0];
      end
      if (wr_now && wr_addr_q == ADDR_GRANT) begin
        grant_q <= hwdata;
      end
    end
  end

  // Grant arithmetic shared by first, middle and last fragment cases
  assign g_len     = grant_q[GR_LEN_LSB +: 16];
  assign g_pend    = grant_q[GR_PEND_BIT];
  assign g_more    = grant_q[GR_MORE_BIT];
  assign g_usable  = (g_len > poh_q) ? g_len - poh_q : 16'h0000;
  assign g_payload = (g_usable > FRAG_OVH_BYTES) ? g_usable - FRAG_OVH_BYTES
                                                 : 16'h0000;
  assign g_fits    = g_payload >= remain_q;
  assign g_short   = umf_slots(remain_q, poh_q) > umf_slots(g_len, 16'h0000);
  assign after_rem = g_fits ? 16'h0000 : remain_q - g_payload;

  // Main sequencer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q       <= UMF_IDLE;
      remain_q      <= 16'h0000;
      frag_active_q <= 1'b0;
      seq_q         <= 4'h0;
      retries_q     <= 8'h00;
      dropped_q     <= 1'b0;
      last_q        <= 1'b0;
    end else begin
      case (state_q)
        UMF_IDLE: begin
          if (req_post_q) begin
            remain_q  <= frame_len_q;
            retries_q <= 8'h00;
            dropped_q <= 1'b0;
            state_q   <= UMF_WAIT_GRANT;
          end
        end
        UMF_WAIT_GRANT, UMF_WAIT_FRAG: begin
          if (grant_post_q && (g_len != 16'h0000)) begin
            state_q <= UMF_SEND;
          end else if (grant_post_q && g_pend) begin
            retries_q <= 8'h00;
          end else if (tmr_expired) begin
            if (retries_q >= retry_limit_q) begin
              state_q <= UMF_DROP;
            end else begin
              retries_q <= retries_q + 8'h01;
            end
          end
        end
        UMF_SEND: begin
          retries_q <= 8'h00;
          if (!frag_active_q) begin
            if (g_short && ctrl_q[CTRL_EN_BIT] && !ctrl_q[CTRL_IMM_BIT]) begin
              frag_active_q <= 1'b1;
              seq_q         <= 4'h0;
              remain_q      <= after_rem;
              state_q       <= UMF_WAIT_FRAG;
            end else begin
              remain_q <= 16'h0000;
              state_q  <= UMF_IDLE;
            end
          end else if (g_fits) begin
            frag_active_q <= 1'b0;
            seq_q         <= seq_q + 4'h1;
            remain_q      <= 16'h0000;
            state_q       <= UMF_IDLE;
          end else begin
            seq_q    <= seq_q + 4'h1;
            remain_q <= after_rem;
            state_q  <= UMF_WAIT_FRAG;
          end
          last_q <= frag_active_q && g_fits;
        end
        UMF_DROP: begin
          dropped_q     <= 1'b1;
          frag_active_q <= 1'b0;
          remain_q      <= 16'h0000;
          state_q       <= UMF_IDLE;
        end
        default: state_q <= UMF_IDLE;
      endcase
    end
  end

  // Fragment header fields, chosen from grant and mode
  always_comb begin
    hdr_load  = 1'b0;
    hdr_first = 1'b0;
    hdr_last  = 1'b0;
    hdr_piggy = 8'h00;
    hdr_len   = 16'h0000;
    tmr_start = 1'b0;
    if (state_q == UMF_SEND) begin
      if (!frag_active_q) begin
        if (g_short && ctrl_q[CTRL_EN_BIT] && !ctrl_q[CTRL_IMM_BIT]) begin
          hdr_load  = 1'b1;
          hdr_first = 1'b1;
          hdr_len   = g_payload;
          // Armed on every non-final fragment so a silent headend is re-requested
          tmr_start = 1'b1;
          if (!g_more && !g_pend) begin
            hdr_piggy = umf_slots(after_rem + FRAG_OVH_BYTES, poh_q);
          end
        end
      end else if (g_fits) begin
        hdr_load = 1'b1;
        hdr_last = 1'b1;
        hdr_len  = remain_q;
        if (!g_more && !g_pend && next_pkt_q != 16'h0000) begin
          hdr_piggy = umf_slots(next_pkt_q, poh_q);
          tmr_start = 1'b1;
        end
      end else begin
        hdr_load = 1'b1;
        hdr_len  = g_payload;
        tmr_start = 1'b1;
        if (!g_more && !g_pend) begin
          hdr_piggy = umf_slots(after_rem + FRAG_OVH_BYTES, poh_q);
        end
      end
    end
    // A grant pending keeps the modem waiting, so the silence timer rearms
    if (grant_post_q && g_pend && (g_len == 16'h0000)) begin
      tmr_start = 1'b1;
    end
    // A grant with pending or more queued leaves piggyback at zero
  end

  // Timer restarts on every request; a re-request also rearms it
  assign tmr_stop = grant_post_q;

  umf_ack_timer u_timer (
    .clock   (clock),
    .reset   (reset),
    .start   (tmr_start || req_post_q || (tmr_expired && retries_q < retry_limit_q)),
    .stop    (tmr_stop),
    .load    (ack_time_q),
    .expired (tmr_expired)
  );

  umf_hdr_build u_hdr (
    .clock       (clock),
    .reset       (reset),
    .load        (hdr_load),
    .first       (hdr_first),
    .last        (hdr_last),
    .seq         (frag_active_q ? seq_q + 4'h1 : 4'h0),
    .piggy       (hdr_piggy),
    .payload_len (hdr_len),
    .header      (fragment_header)
  );

  // Transmit strobes and the re-request channel
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frag_valid   <= 1'b0;
      req_valid    <= 1'b0;
      req_slots    <= 8'h00;
      frags_sent_q <= 16'h0000;
      drops_q      <= 16'h0000;
    end else begin
      frag_valid <= hdr_load;
      req_valid  <= 1'b0;
      if (hdr_load) begin
        frags_sent_q <= frags_sent_q + 16'h0001;
      end
      if (state_q == UMF_DROP) begin
        drops_q <= drops_q + 16'h0001;
      end
      if (req_post_q && state_q == UMF_IDLE) begin
        req_valid <= 1'b1;
        req_slots <= umf_slots(frame_len_q, poh_q);
      end else if (tmr_expired && retries_q < retry_limit_q
                   && (state_q == UMF_WAIT_GRANT || state_q == UMF_WAIT_FRAG)) begin
        req_valid <= 1'b1;
        req_slots <= umf_slots(remain_q + (frag_active_q ? FRAG_OVH_BYTES
                                                          : 16'h0000), poh_q);
      end
    end
  end

endmodule

// ### verif/umf_engine_props.sv
// Checker for the fragmentation engine, watching its top ports only.
// Assumes one clock domain and the zero-wait bus timing of the engine.
module umf_engine_props import umf_pkg::*; (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        frag_valid,
  input wire logic [31:0] fragment_header,
  input wire logic        req_valid,
  input wire logic [7:0]  req_slots
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [3:0] seq_q;
  logic       open_q;
  logic       wr_grant;
  logic       wr_req;
  assign wr_grant = hsel && hready && htrans[1] && hwrite && haddr[7:0] == ADDR_GRANT;
  assign wr_req   = hsel && hready && htrans[1] && hwrite && haddr[7:0] == ADDR_REQ;
  // Remembers the previous fragment so that continuity can be judged
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      seq_q  <= 4'h0;
      open_q <= 1'b0;
    end else if (frag_valid) begin
      seq_q  <= fragment_header[27:24];
      open_q <= !fragment_header[30];
    end
  end
  a_ready_always: assert property (hreadyout)
    else $error("bus stalled");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_flag_pair: assert property (frag_valid |-> !(fragment_header[31] && fragment_header[30]))
    else $error("first and last together");
  a_seq_step: assert property (frag_valid && !fragment_header[31] |->
    fragment_header[27:24] == seq_q + 4'h1)
    else $error("sequence not advanced by one");
  a_middle_open: assert property (frag_valid && !fragment_header[31] |-> open_q)
    else $error("continuation without open frame");
  a_frag_cause: assert property (frag_valid |-> $past(wr_grant, 4))
    else $error("fragment without grant");
  a_req_start: assert property (wr_req |-> ##3 req_valid)
    else $error("no request after frame start");
  a_req_single: assert property (req_valid |=> !req_valid)
    else $error("request longer than a pulse");
  a_req_nonzero: assert property (req_valid |-> req_slots != 8'h00)
    else $error("empty request");
endmodule

bind umf_engine umf_engine_props u_props (
  .clock           (clock),
  .reset           (reset),
  .hsel            (hsel),
  .haddr           (haddr),
  .htrans          (htrans),
  .hwrite          (hwrite),
  .hready          (hready),
  .hreadyout       (hreadyout),
  .hresp           (hresp),
  .frag_valid      (frag_valid),
  .fragment_header (fragment_header),
  .req_valid       (req_valid),
  .req_slots       (req_slots)
);

// ### verif/umf_headend_model.sv
// Headend model: reassembles fragments and keeps the demand handed to it.
// Assumes the engine's header layout and one-cycle frag_valid pulses.
module umf_headend_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        frag_valid,
  input  wire logic [31:0] fragment_header,
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_slots,
  output logic [31:0]      asm_bytes,
  output logic [7:0]       pend_slots,
  output logic             asm_err
);
  logic [3:0] seq_q;
  logic       open_q;
  // Payload counted from just after the header, as decryption would be
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      asm_bytes <= 32'h0;
      seq_q     <= 4'h0;
      open_q    <= 1'b0;
      asm_err   <= 1'b0;
    end else if (frag_valid) begin
      seq_q     <= fragment_header[27:24];
      open_q    <= !fragment_header[30];
      asm_bytes <= (fragment_header[31] ? 32'h0 : asm_bytes) + 32'(fragment_header[15:0]);
      if (!fragment_header[31] && (!open_q || fragment_header[27:24] != seq_q + 4'h1))
        asm_err <= 1'b1;
    end
  end
  // A re-request replaces the demand, so a missed grant is recovered
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      pend_slots <= 8'h00;
    else if (frag_valid && fragment_header[23:16] != 8'h00)
      pend_slots <= fragment_header[23:16];
    else if (req_valid)
      pend_slots <= req_slots;
  end
endmodule

// ### verif/upstream_mac_fragmentation_test.sv
// Self-checking bench for the fragmentation engine over AHB-Lite.
// Assumes zero-wait bus answers and a 20-cycle acknowledgement time.
module upstream_mac_fragmentation_test;
  timeunit 1ns;
  timeprecision 1ps;
  import umf_pkg::*;
  localparam int P = int'(POH_RESET);
  logic        clock;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        frag_valid;
  logic [31:0] fragment_header;
  logic        req_valid;
  logic [7:0]  req_slots;
  logic [31:0] asm_bytes;
  logic [7:0]  pend_slots;
  logic        asm_err;
  logic [31:0] hdr;
  logic [31:0] seed;
  logic [7:0]  rslots;
  int          fail_count;
  int          compares;
  int          nfrag;
  int          nreq;
  int          cyc;
  int          n;
  umf_engine dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frag_valid(frag_valid), .fragment_header(fragment_header),
    .req_valid(req_valid), .req_slots(req_slots));
  umf_headend_model he (.clock(clock), .reset(reset), .frag_valid(frag_valid),
    .fragment_header(fragment_header), .req_valid(req_valid),
    .req_slots(req_slots), .asm_bytes(asm_bytes), .pend_slots(pend_slots),
    .asm_err(asm_err));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (frag_valid === 1'b1) begin
      nfrag++;
      hdr = fragment_header;
    end
    if (req_valid === 1'b1) begin
      nreq++;
      rslots = req_slots;
    end
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      conclude();
    end
  end
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] sl(input int b);
    return 8'((b + P + 15) / 16);
  endfunction
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic br(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(hrdata & m, e);
  endtask
  task automatic waitn(ref int c, input int old, input int lim);
    int i;
    i = 0;
    while (c == old && i < lim) begin
      @(posedge clock);
      i++;
    end
    chk(32'(c != old), 32'h1);
  endtask
  task automatic frame(input int len, input int g, input logic mg, input int nx,
                       input logic tmo);
    int rem;
    int pl;
    int k;
    int gg;
    logic lst;
    logic [7:0] pg;
    rem = len;
    k = 0;
    bw(ADDR_NEXTPKT, {8'h00, 8'h10, 16'(nx)});
    n = nreq;
    bw(ADDR_REQ, 32'(len));
    waitn(nreq, n, 10);
    chk({24'h0, rslots}, {24'h0, sl(len)});
    do begin
      // A remainder too small to carry its own overhead is granted whole
      gg = (k > 0 && rem > g - 16 - P && rem < g + 48 - P) ? rem + 16 + P : g;
      lst = rem + 16 + P <= gg;
      pl = lst ? rem : gg - 16 - P;
      rem = rem - pl;
      pg = lst ? (nx == 0 ? 8'h00 : sl(nx)) : (mg ? 8'h00 : sl(rem + 16));
      if (mg && k > 0) bw(ADDR_GRANT, 32'h0001_0000);
      n = nfrag;
      bw(ADDR_GRANT, {14'h0, mg & !lst & k[0], mg & !lst & !k[0], 16'(gg)});
      waitn(nfrag, n, 12);
      chk(hdr & 32'hF0FF_FFFF, {k == 0, lst, 6'h0, pg, 16'(pl)});
      if (tmo && !lst && k == 0) begin
        n = nreq;
        waitn(nreq, n, 60);
        chk({24'h0, rslots}, {24'h0, sl(rem + 16)});
        @(posedge clock);
        chk({24'h0, pend_slots}, {24'h0, sl(rem + 16)});
      end
      k++;
    end while (!lst);
    @(posedge clock);
    chk(asm_bytes, 32'(len));
    $display("frame of %0d bytes done", len);
  endtask
  initial begin
    logic [31:0] tb [3];
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    reset = 1'b1;
    seed = 32'hFBCE86C4;
    tb = '{32'h0005_01F4, 32'h0000_01F4, 32'h0001_0064};
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    br(ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
    br(ADDR_POH, 32'hFFFF_FFFF, 32'(POH_RESET));
    br(ADDR_ACKTIME, 32'hFFFF_FFFF, ACK_TIME_RESET);
    br(ADDR_NEXTPKT, 32'h00FF_0000, {8'h0, RETRY_LIMIT_RESET, 16'h0});
    bw(8'h40, 32'h1234_5678);
    br(8'h40, 32'hFFFF_FFFF, 32'h0);
    $display("register test done");
    bw(ADDR_CTRL, 32'h1);
    bw(ADDR_ACKTIME, 32'h0000_0014);
    frame(1018, 948, 1'b0, 0, 1'b1);
    frame(1018, 948, 1'b1, 0, 1'b0);
    frame(600, 200, 1'b0, 300, 1'b0);
    bw(ADDR_CTRL, 32'h3);
    frame(700, 150, 1'b1, 0, 1'b0);
    bw(ADDR_CTRL, 32'h1);
    for (int i = 0; i < 8; i++) begin
      seed = lf(seed);
      n = 300 + int'(seed % 1200);
      seed = lf(seed);
      frame(n, 100 + int'(seed % 200), seed[7], 0, 1'b0);
    end
    // Immediate-data, disabled and full grants must leave frames whole
    for (int i = 0; i < 3; i++) begin
      bw(ADDR_CTRL, {16'h0, tb[i][31:16]});
      bw(ADDR_REQ, {16'h0, tb[i][15:0]});
      n = nfrag;
      bw(ADDR_GRANT, 32'(i == 2 ? 400 : 100));
      repeat (10) @(posedge clock);
      chk(32'(nfrag), 32'(n));
    end
    $display("no-fragment test done");
    bw(ADDR_CTRL, 32'h1);
    bw(ADDR_NEXTPKT, 32'h0002_0000);
    n = nreq;
    bw(ADDR_REQ, 32'h0000_0190);
    repeat (200) @(posedge clock);
    chk(32'(nreq - n > 1), 32'h1);
    br(ADDR_STATUS, 32'h4, 32'h4);
    chk({31'h0, asm_err}, 32'h0);
    $display("retry test done");
    conclude();
  end
endmodule
